// File: flash_prog_port.v
// on-board flash programming front end: protocol select and command sequencer
// Functional notes
// - the count of pulses on the programming-voltage pin picks channel 0, channel 1 or handshake.
// - handshake mode adds a busy/ready handshake line to channel 0, unused in plain serial mode.
// - after selection every operation runs as commands, data and answers over the chosen link.
// - an erase command clears the whole 16 KB area named by the command.
// - a blank check reads the named area and answers whether all of it is erased.
// - a write takes a start address and a byte count, then programs that many data bytes.
// - a verify compares streamed bytes with a named area or with the whole array.
// - after a verify only a pass or fail answer goes out, never the differing data.
// - no command ever sends array contents out over the link.
`timescale 1ns/10ps
`include "flash_prog_defs.vh"
module flash_prog_port #(
  parameter ADDR_W = 16,
  parameter AREA_COUNT = 4,
  parameter CLK_MHZ = 50,
  parameter SELECT_CYCLES = `SELECT_WINDOW_US * CLK_MHZ
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_vpp_pin,
  input wire i_serial0_clock_pin,
  input wire i_serial0_in_pin,
  output wire o_serial0_out_pin,
  input wire i_serial1_clock_pin,
  input wire i_serial1_in_pin,
  output wire o_serial1_out_pin,
  output wire o_handshake_port_line,
  output wire o_handshake_port_line_oe_n,
  output wire [1:0] o_mode,
  output wire o_busy
);
  localparam ST_SELECT = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_PARAM = 3'h2;
  localparam ST_EXEC = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_IDLE = 3'h5;
  localparam MEM_DEPTH = AREA_COUNT << `AREA_BYTES_LOG2;
  localparam [31:0] MEM_LAST = MEM_DEPTH - 1;
  reg [7:0] mem [0:MEM_DEPTH-1];
  reg [1:0] vpp_sync;
  reg vpp_last;
  reg [2:0] pulse_cnt;
  reg [31:0] sel_timer;
  reg [1:0] mode;
  reg [2:0] state;
  reg [7:0] cmd;
  reg [2:0] param_idx;
  reg [ADDR_W-1:0] addr;
  reg [ADDR_W-1:0] last_addr;
  reg [15:0] count;
  reg mismatch;
  reg [7:0] answer;
  reg link_clear;
  reg serial0_out;
  reg serial1_out;
  wire rx0_valid;
  wire rx1_valid;
  wire [7:0] rx0_byte;
  wire [7:0] rx1_byte;
  wire sout0;
  wire sout1;
  wire rx_valid;
  wire [7:0] rx_byte;
  wire [ADDR_W-1:0] area_base;
  wire [ADDR_W-1:0] area_last;
  wire [ADDR_W-1:0] area_size;

  serial_byte_link u_link0 (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_clear(link_clear),
    .i_sck(i_serial0_clock_pin),
    .i_sin(i_serial0_in_pin),
    .i_tx_byte(answer),
    .o_rx_valid(rx0_valid),
    .o_rx_byte(rx0_byte),
    .o_sout(sout0)
  );
  serial_byte_link u_link1 (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_clear(link_clear),
    .i_sck(i_serial1_clock_pin),
    .i_sin(i_serial1_in_pin),
    .i_tx_byte(answer),
    .o_rx_valid(rx1_valid),
    .o_rx_byte(rx1_byte),
    .o_sout(sout1)
  );

  // only the selected channel carries commands
  assign rx_valid = (mode == `MODE_SERIAL1) ? rx1_valid :
                    ((mode == `MODE_NONE) ? 1'b0 : rx0_valid);
  assign rx_byte = (mode == `MODE_SERIAL1) ? rx1_byte : rx0_byte;
  assign o_serial0_out_pin = serial0_out;
  assign o_serial1_out_pin = serial1_out;
  // handshake line driven low while busy, only in handshake mode
  assign o_handshake_port_line = (state == ST_CMD || state == ST_PARAM || state == ST_DATA);
  assign o_handshake_port_line_oe_n = (mode != `MODE_HANDSHAKE);
  assign o_mode = mode;
  assign o_busy = (state == ST_EXEC);
  // area number in the first parameter byte, areas 16 KB each
  assign area_size = {{(ADDR_W-1){1'b0}}, 1'b1} << `AREA_BYTES_LOG2;
  assign area_base = addr[ADDR_W-1:0] & ~(area_size - {{(ADDR_W-1){1'b0}}, 1'b1});
  assign area_last = area_base + area_size - {{(ADDR_W-1){1'b0}}, 1'b1};

  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      vpp_sync <= 2'h0;
      vpp_last <= 1'b0;
      serial0_out <= 1'b1;
      serial1_out <= 1'b1;
    end else begin
      vpp_sync <= {vpp_sync[0], i_vpp_pin};
      vpp_last <= vpp_sync[1];
      // unused channel idles high so a stray programmer sees no data
      serial0_out <= (mode == `MODE_SERIAL0 || mode == `MODE_HANDSHAKE) ? sout0 : 1'b1;
      serial1_out <= (mode == `MODE_SERIAL1) ? sout1 : 1'b1;
    end
  end

  // memory side effects kept in their own process so the array infers as ram
  always @(posedge i_clk_sys) begin
    if (state == ST_EXEC && cmd == `CMD_ERASE) begin
      mem[addr] <= `ERASED_BYTE;
    end else if (state == ST_DATA && rx_valid && cmd == `CMD_WRITE) begin
      mem[addr] <= rx_byte;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pulse_cnt <= 3'h0;
      sel_timer <= 32'h0000_0000;
      mode <= `MODE_NONE;
      state <= ST_SELECT;
      cmd <= 8'h00;
      param_idx <= 3'h0;
      addr <= {ADDR_W{1'b0}};
      last_addr <= {ADDR_W{1'b0}};
      count <= 16'h0000;
      mismatch <= 1'b0;
      answer <= 8'h00;
      link_clear <= 1'b1;
    end else begin
      link_clear <= 1'b0;
      case (state)
        ST_SELECT: begin
          // count falling pulses on vpp in a fixed window after reset
          if (vpp_last && !vpp_sync[1] && pulse_cnt != 3'h7) begin
            pulse_cnt <= pulse_cnt + 3'h1;
          end
          sel_timer <= sel_timer + 32'h0000_0001;
          if (sel_timer == SELECT_CYCLES - 1) begin
            link_clear <= 1'b1;
            state <= ST_CMD;
            if (pulse_cnt == `PULSES_SERIAL0) begin
              mode <= `MODE_SERIAL0;
            end else if (pulse_cnt == `PULSES_SERIAL1) begin
              mode <= `MODE_SERIAL1;
            end else if (pulse_cnt == `PULSES_HANDSHAKE) begin
              mode <= `MODE_HANDSHAKE;
            end else begin
              // undefined count, stay out of every protocol
              state <= ST_IDLE;
            end
          end
        end
        ST_CMD: begin
          if (rx_valid) begin
            cmd <= rx_byte;
            param_idx <= 3'h0;
            addr <= {ADDR_W{1'b0}};
            count <= 16'h0000;
            mismatch <= 1'b0;
            // unknown commands, reads included, only get a refusal
            case (rx_byte)
              `CMD_ERASE, `CMD_BLANK, `CMD_WRITE, `CMD_VERIFY: begin
                answer <= `RSP_ACK;
                state <= ST_PARAM;
              end
              `CMD_VERIFY_ALL: begin
                // whole array verify starts at zero
                answer <= `RSP_ACK;
                last_addr <= MEM_LAST[ADDR_W-1:0];
                state <= ST_DATA;
              end
              default: begin
                answer <= `RSP_NAK;
              end
            endcase
          end
        end
        ST_PARAM: begin
          if (rx_valid) begin
            param_idx <= param_idx + 3'h1;
            if (cmd == `CMD_WRITE) begin
              // address high, address low, count high, count low
              case (param_idx)
                3'h0: addr <= {rx_byte, 8'h00};
                3'h1: addr <= {addr[ADDR_W-1:8], rx_byte};
                3'h2: count <= {rx_byte, 8'h00};
                default: begin
                  count <= {count[15:8], rx_byte};
                  last_addr <= addr + {count[15:8], rx_byte} - 1'b1;
                  state <= (count[15:8] == 8'h00 && rx_byte == 8'h00) ? ST_CMD : ST_DATA;
                end
              endcase
            end else begin
              addr <= {rx_byte[ADDR_W-`AREA_BYTES_LOG2-1:0], {`AREA_BYTES_LOG2{1'b0}}};
              state <= (cmd == `CMD_VERIFY) ? ST_DATA : ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (param_idx != 3'h7) begin
            addr <= area_base;
            param_idx <= 3'h7;
          end else begin
            // any non-erased byte fails the blank check
            if (cmd == `CMD_BLANK && mem[addr] != `ERASED_BYTE) begin
              mismatch <= 1'b1;
            end
            addr <= addr + 1'b1;
            if (addr == area_last) begin
              answer <= (mismatch || (cmd == `CMD_BLANK && mem[addr] != `ERASED_BYTE)) ?
                        `RSP_FAIL : `RSP_PASS;
              state <= ST_CMD;
            end
          end
        end
        ST_DATA: begin
          if (cmd == `CMD_VERIFY && param_idx != 3'h7) begin
            addr <= area_base;
            last_addr <= area_last;
            param_idx <= 3'h7;
          end else if (rx_valid) begin
            // compare each streamed byte with the array, except during a write
            if (cmd != `CMD_WRITE && mem[addr] != rx_byte) begin
              mismatch <= 1'b1;
            end
            addr <= addr + 1'b1;
            if (addr == last_addr) begin
              // only pass or fail is returned after a verify
              answer <= (cmd == `CMD_WRITE) ? `RSP_ACK :
                        ((mismatch || mem[addr] != rx_byte) ? `RSP_FAIL : `RSP_PASS);
              state <= ST_CMD;
            end
          end
        end
        ST_IDLE: begin
          mode <= `MODE_NONE;
        end
        default: begin
          state <= ST_SELECT;
        end
      endcase
    end
  end
endmodule // flash_prog_port

// File: flash_prog_defs.vh
// constants for the on-board flash programming port
`ifndef FLASH_PROG_DEFS_VH
`define FLASH_PROG_DEFS_VH
`define PULSES_SERIAL0 3'h0
`define PULSES_SERIAL1 3'h1
`define PULSES_HANDSHAKE 3'h3
`define MODE_NONE 2'h0
`define MODE_SERIAL0 2'h1
`define MODE_SERIAL1 2'h2
`define MODE_HANDSHAKE 2'h3
`define CMD_ERASE 8'h20
`define CMD_BLANK 8'h32
`define CMD_WRITE 8'h40
`define CMD_VERIFY 8'h13
`define CMD_VERIFY_ALL 8'h14
`define RSP_ACK 8'h3c
`define RSP_NAK 8'hff
`define RSP_PASS 8'h3c
`define RSP_FAIL 8'h55
`define ERASED_BYTE 8'hff
`define AREA_BYTES_LOG2 14
`define SELECT_WINDOW_US 1000
`endif

// File: serial_byte_link.v
// serial byte shifter sampled on the system clock, clocked by the programmer
`timescale 1ns/10ps
module serial_byte_link (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_clear,
  input wire i_sck,
  input wire i_sin,
  input wire [7:0] i_tx_byte,
  output reg o_rx_valid,
  output reg [7:0] o_rx_byte,
  output wire o_sout
);
  reg [2:0] sck_sync;
  reg [1:0] sin_sync;
  reg [2:0] bit_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  wire sck_rise;
  wire sck_fall;
  // edges found on the second and third stage, never the first
  assign sck_rise = sck_sync[1] & ~sck_sync[2];
  assign sck_fall = ~sck_sync[1] & sck_sync[2];
  assign o_sout = tx_shift[7];
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sck_sync <= 3'h7;
      sin_sync <= 2'h0;
    end else begin
      sck_sync <= {sck_sync[1:0], i_sck};
      sin_sync <= {sin_sync[0], i_sin};
    end
  end
  always @(posedge i_clk_sys) begin
    if (!i_resetn || i_clear) begin
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
    end else begin
      o_rx_valid <= 1'b0;
      if (sck_rise) begin
        rx_shift <= {rx_shift[6:0], sin_sync[1]};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          o_rx_valid <= 1'b1;
          o_rx_byte <= {rx_shift[6:0], sin_sync[1]};
        end
      end
      // next answer byte loads at a byte boundary, msb first on falling edges
      if (sck_fall) begin
        if (bit_cnt == 3'h0) begin
          tx_shift <= i_tx_byte;
        end else begin
          tx_shift <= {tx_shift[6:0], 1'b0};
        end
      end
    end
  end
endmodule // serial_byte_link

// File: fpp_checker.sv
// pin checker for the flash programming port
`timescale 1ns/10ps
module fpp_checker (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire o_serial0_out_pin,
  input wire o_serial1_out_pin,
  input wire o_handshake_port_line,
  input wire o_handshake_port_line_oe_n,
  input wire [1:0] o_mode,
  input wire o_busy
);
  reg [15:0] busy_len;
  always @(posedge i_clk_sys) begin
    busy_len <= (!i_resetn || !o_busy) ? 16'h0000 : busy_len + 16'h0001;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_mode_held: assert property (o_mode != 2'h0 |=> $stable(o_mode))
    else $error("mode moved");
  a_hs_quiet: assert property (o_mode != 2'h3 |-> o_handshake_port_line_oe_n)
    else $error("handshake driven");
  // ready may lag busy by a cycle or two
  a_hs_busy: assert property ((o_mode == 2'h3 && o_busy) [*3] |-> !o_handshake_port_line)
    else $error("ready while busy");
  a_spare0_high: assert property (o_mode == 2'h2 |-> o_serial0_out_pin)
    else $error("spare out low");
  a_spare1_high: assert property (o_mode[0] |-> o_serial1_out_pin)
    else $error("spare out low");
  a_busy_span: assert property ($fell(o_busy) |-> busy_len >= 16'h4000)
    else $error("busy too short");
  a_idle_quiet: assert property (o_mode == 2'h0 |->
    o_serial0_out_pin && o_serial1_out_pin && !o_busy) else $error("idle not quiet");
  a_no_leak: assert property (o_busy |->
    $stable(o_serial0_out_pin) && $stable(o_serial1_out_pin)) else $error("out moved");
  c_hs: cover property (o_mode == 2'h3);
  c_ch1: cover property (o_mode == 2'h2);
  c_done: cover property ($fell(o_busy));
endmodule // fpp_checker
bind flash_prog_port fpp_checker u_chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .o_serial0_out_pin(o_serial0_out_pin), .o_serial1_out_pin(o_serial1_out_pin),
  .o_handshake_port_line(o_handshake_port_line), .o_mode(o_mode), .o_busy(o_busy),
  .o_handshake_port_line_oe_n(o_handshake_port_line_oe_n));

// File: fpp_programmer.sv
// behavioural programmer: selection pulses and serial bytes
`timescale 1ns/10ps
module fpp_programmer (
  input wire i_clk_sys,
  input wire i_sout0,
  input wire i_sout1,
  input wire i_ready,
  output reg o_vpp,
  output wire o_sclk0,
  output wire o_sin0,
  output wire o_sclk1,
  output wire o_sin1
);
  reg chan = 1'b0;
  reg hs = 1'b0;
  reg sclk = 1'b1;
  reg sin = 1'b1;
  // the channel not in use stays idle high
  assign o_sclk0 = chan | sclk;
  assign o_sin0 = chan | sin;
  assign o_sclk1 = !chan | sclk;
  assign o_sin1 = !chan | sin;
  initial o_vpp = 1'b0;
  task pulses(input integer n);
    repeat (n) begin
      repeat (4) @(posedge i_clk_sys);
      #2 o_vpp = 1'b1;
      repeat (4) @(posedge i_clk_sys);
      #2 o_vpp = 1'b0;
    end
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 0; hs && i_ready !== 1'b1 && i < 40000; i = i + 1) @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    for (i = 7; i >= 0; i = i - 1) begin
      #2 sclk = 1'b0;
      sin = tx[i];
      repeat (4) @(posedge i_clk_sys);
      #2 sclk = 1'b1;
      repeat (4) @(posedge i_clk_sys);
      rx[i] = chan ? i_sout1 : i_sout0;
    end
    // a finished byte must not leave a trusted level behind
    #2 sin = ~sin;
    repeat (6) @(posedge i_clk_sys);
  endtask
endmodule // fpp_programmer

// File: tb_top.sv
// testbench: link selection and command runs on each link
`timescale 1ns/10ps
`include "flash_prog_defs.vh"
module tb_top;
  reg i_clk_sys;
  reg i_resetn = 1'b0;
  wire vpp, serial0_clock_pin, sin0, serial1_clock_pin, sin1, so0, so1, hs_line, oe_n, busy;
  wire [1:0] mode;
  // a released handshake line is pulled up
  wire ready = oe_n | hs_line;
  integer n_fail = 0;
  integer comparisons = 0;
  reg [7:0] rx;
  flash_prog_port #(.SELECT_CYCLES(200)) dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_vpp_pin(vpp), .i_serial0_clock_pin(serial0_clock_pin), .i_serial0_in_pin(sin0),
    .o_serial0_out_pin(so0), .i_serial1_clock_pin(serial1_clock_pin), .i_serial1_in_pin(sin1),
    .o_serial1_out_pin(so1), .o_handshake_port_line(hs_line),
    .o_handshake_port_line_oe_n(oe_n), .o_mode(mode), .o_busy(busy));
  fpp_programmer prog (.i_clk_sys(i_clk_sys), .i_sout0(so0), .i_sout1(so1), .i_ready(ready),
    .o_vpp(vpp), .o_sclk0(serial0_clock_pin), .o_sin0(sin0), .o_sclk1(serial1_clock_pin), .o_sin1(sin1));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task settle(input integer n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask
  task send(input [7:0] b);
    prog.xfer(b, rx);
  endtask
  task send_seq(input [63:0] seq, input integer n);
    integer k;
    for (k = n - 1; k >= 0; k = k - 1) send(seq[8*k +: 8]);
  endtask
  task start(input integer n, input [1:0] exp);
    settle(1);
    i_resetn = 1'b0;
    prog.chan = n == 1;
    prog.hs = n == 3;
    settle(20);
    i_resetn = 1'b1;
    prog.pulses(n);
    settle(210);
    check("mode", {6'h00, mode}, {6'h00, exp});
  endtask
  task wait_idle;
    integer w;
    for (w = 0; busy !== 1'b0 && w < 20000; w = w + 1) @(posedge i_clk_sys);
    settle(1);
    check("busy", busy, 8'h00);
  endtask
  task sc_bad_count;
    start(2, `MODE_NONE);
    send_seq(64'h0000_0000_0000_2001, 2);
    check("busy", busy, 8'h00);
    send(8'h00);
    check("answer", rx, 8'hff);
  endtask
  task sc_ch0;
    start(0, `MODE_SERIAL0);
    check("oe_n", oe_n, 8'h01);
    send_seq(64'h0000_0000_0000_2001, 2);
    settle(10);
    check("busy", busy, 8'h01);
    wait_idle;
    send(`CMD_BLANK);
    check("erase", rx, `RSP_PASS);
    send(8'h01);
    wait_idle;
    send(`CMD_WRITE);
    check("blank", rx, `RSP_PASS);
    send_seq(64'h0000_007f_ff00_015a, 5);
    settle(20);
    send(`CMD_BLANK);
    check("write", rx, `RSP_ACK);
    send(8'h01);
    wait_idle;
    send(8'h00);
    check("blank", rx, `RSP_FAIL);
    send(8'h00);
    check("nak", rx, `RSP_NAK);
  endtask
  task sc_ch1;
    start(1, `MODE_SERIAL1);
    send_seq(64'h0040_4000_0002_a53c, 7);
    settle(20);
    send(8'h00);
    check("write", rx, `RSP_ACK);
    send(8'h00);
    check("nak", rx, `RSP_NAK);
    send(`CMD_VERIFY);
    send(8'h01);
    check("verify", rx, `RSP_ACK);
    send(8'ha5);
    check("no data", rx, `RSP_ACK);
  endtask
  task sc_hs;
    start(3, `MODE_HANDSHAKE);
    check("oe_n", oe_n, 8'h00);
    send_seq(64'h0000_0000_0000_2003, 2);
    settle(10);
    check("ready", ready, 8'h00);
    wait_idle;
    check("ready", ready, 8'h01);
    send(8'h00);
    check("erase", rx, `RSP_PASS);
    send(`CMD_VERIFY_ALL);
    send(8'hff);
    check("verify all", rx, `RSP_ACK);
  endtask
  initial begin
    sc_bad_count;
    sc_ch0;
    sc_ch1;
    sc_hs;
    print_verdict;
  end
  // the full run needs about 70000 cycles
  initial begin
    #1_800_000;
    n_fail = n_fail + 1;
    print_verdict;
  end
endmodule // tb_top
